/* mst_pkg.sv */
package mst_pkg;

   // Clock and timebase
   localparam int unsigned CLOCK_PERIOD_NS = 10;
   localparam int unsigned TICK_TIME_NS    = 100000;
   localparam int unsigned TICK_CYCLES     = TICK_TIME_NS / CLOCK_PERIOD_NS;
   localparam int unsigned TICK_W          = 14;

   // Field widths; all times are in 0.1 ms ticks
   localparam int unsigned TIME_W  = 17;
   localparam int unsigned WIDTH_W = 18;
   localparam int unsigned THR_W   = 22;
   localparam int unsigned ERR_W   = 32;

   // Setting limits and reset defaults
   localparam logic [TIME_W-1:0]         TIME_MAX          = 17'h186A0;
   localparam logic [THR_W-1:0]          THRESHOLD_MAX     = 22'h27FFFF;
   localparam logic [ERR_W-1:0]          COUNTS_PER_REV    = 32'h00280000;
   localparam logic [TIME_W-1:0]         DEF_BUSY_HOLD     = 17'h00000;
   localparam logic signed [WIDTH_W-1:0] DEF_MODE_WIDTH    = 18'sh3FFF6;
   localparam logic [THR_W-1:0]          DEF_THRESHOLD     = 22'h000190;
   localparam logic [TIME_W-1:0]         DEF_STABILITY     = 17'h00000;
   localparam logic [TIME_W-1:0]         TIME_ZERO         = 17'h00000;
   localparam logic [TICK_W-1:0]         TICK_ZERO         = 14'h0000;

   typedef enum logic [1:0] {
      MODE_LATCHED  = 2'b00,
      MODE_TRACKING = 2'b01,
      MODE_PULSED   = 2'b10
   } mst_mode_type;

   typedef enum logic [2:0] {
      ST_LOST   = 3'b000,
      ST_MOVING = 3'b001,
      ST_SETTLE = 3'b010,
      ST_HELD   = 3'b011,
      ST_PULSE  = 3'b100,
      ST_DONE   = 3'b101
   } mst_state_type;

   typedef struct packed {
      logic [TIME_W-1:0]         busy_hold_time;
      logic signed [WIDTH_W-1:0] settle_report_mode_width;
      logic [THR_W-1:0]          threshold;
      logic [TIME_W-1:0]         settle_stability_time;
   } mst_config_type;

   typedef struct packed {
      logic program_run;
      logic position_first;
      logic jog;
      logic self_tune_cmd;
      logic home_return;
   } mst_ops_type;

endpackage

/* mst_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module mst_timer
   import mst_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_arst_n,
   // Control
   input  wire logic              i_tick,
   input  wire logic              i_load,
   input  wire logic [TIME_W-1:0] i_value,
   // Status
   output logic                   o_running
);

   logic [TIME_W-1:0] count;
   logic [TIME_W-1:0] next_count;

   always_comb begin
      next_count = count;
      if (i_load) begin
         next_count = i_value;
      end else if (i_tick && count != TIME_ZERO) begin
         next_count = count - 17'h00001;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count <= TIME_ZERO;
      end else begin
         count <= next_count;
      end
   end

   assign o_running = (count != TIME_ZERO);

endmodule
`default_nettype wire

/* mst_motion_status.sv */
// Functional notes
// - Servo-state output follows servo active level.
// - Busy closed for internal operations, not pulses.
// - Busy held at least the hold time.
// - Next command accepted during busy hold window.
// - Settled closes only when completed and retained.
// - Settled open after reset or interruption.
// - Halt while moving, servo off, stops lose target.
// - Mode width sign selects reporting mode.
// - In tolerance when abs error within threshold.
// - Settled open stability time after start.
// - Latched start opens for width and stability.
// - Latched closes in tolerance, holds until start.
// - Tracking closes only while error within threshold.
// - Pulsed closes for width minus one to width ticks.
// - Pulsed start reopens output immediately.
// - Pulse-train pauses re-evaluate completion.
// - Threshold counted in position-sensor counts.
// - Latched/pulsed need tolerance for whole stability.
// - Alert closed after init when no warning.
`timescale 1ns/1ps
`default_nettype none
module mst_motion_status
   import mst_pkg::*;
#(
   parameter int unsigned P_TICK_CYCLES = TICK_CYCLES
)(
   // Clock and reset
   input  wire logic                    i_clock,
   input  wire logic                    i_arst_n,
   // Settings
   input  wire mst_config_type          i_config,
   // Drive state
   input  wire logic                    i_init_done,
   input  wire logic                    i_servo_active,
   input  wire logic                    i_warning,
   input  wire logic                    i_halt_request,
   // Operations in progress
   input  wire mst_ops_type             i_ops,
   // Motion events, one-cycle pulses
   input  wire logic                    i_start,
   input  wire logic                    i_target_reached,
   input  wire logic                    i_train_pulse,
   input  wire logic                    i_train_pause,
   input  wire logic                    i_alarm_stop,
   input  wire logic                    i_warning_stop,
   input  wire logic                    i_limit_stop,
   // Residual error counter
   input  wire logic signed [ERR_W-1:0] i_residual_error,
   // Status outputs, 1 means closed
   output logic                         o_servo_state_out,
   output logic                         o_busy_out,
   output logic                         o_settled_out,
   output logic                         o_alert_flag,
   output logic                         o_cmd_accept
);

   function automatic logic [TIME_W-1:0] clamp_time(input logic [TIME_W-1:0] v);
      clamp_time = (v > TIME_MAX) ? TIME_MAX : v;
   endfunction

   // One extra tick covers the unknown phase of the shared tick
   function automatic logic [TIME_W-1:0] min_ticks(input logic [TIME_W-1:0] v);
      logic [TIME_W-1:0] c;
      c = clamp_time(v);
      min_ticks = (c == TIME_ZERO) ? TIME_ZERO : c + 17'h00001;
   endfunction

   // Clamp before narrowing: the most negative setting has a magnitude one bit too wide
   function automatic logic [TIME_W-1:0] width_mag(input logic signed [WIDTH_W-1:0] w);
      logic [WIDTH_W-1:0] m;
      m = (w < 0) ? WIDTH_W'(-w) : WIDTH_W'(w);
      width_mag = (m > WIDTH_W'(TIME_MAX)) ? TIME_MAX : m[TIME_W-1:0];
   endfunction

   function automatic mst_mode_type mode_of(input logic signed [WIDTH_W-1:0] w);
      if (w < 0) begin
         mode_of = MODE_LATCHED;
      end else if (w == 0) begin
         mode_of = MODE_TRACKING;
      end else begin
         mode_of = MODE_PULSED;
      end
   endfunction

   // Common tick
   logic [TICK_W-1:0] tick_count;
   logic [TICK_W-1:0] next_tick_count;
   logic              tick;
   logic              next_tick;

   always_comb begin
      next_tick = (tick_count == TICK_W'(P_TICK_CYCLES - 1));
      next_tick_count = next_tick ? TICK_ZERO : tick_count + 14'h0001;
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tick_count <= TICK_ZERO;
         tick       <= 1'b0;
      end else begin
         tick_count <= next_tick_count;
         tick       <= next_tick;
      end
   end

   // Derived conditions
   mst_mode_type      mode;
   logic [ERR_W-1:0]  abs_error;
   logic              in_tol;
   logic              op_any;
   logic              abort;
   logic              start_any;

   assign mode      = mode_of(i_config.settle_report_mode_width);
   assign abs_error = i_residual_error[ERR_W-1] ? ERR_W'(-i_residual_error)
                                                : ERR_W'(i_residual_error);
   // Threshold and error share position-sensor counts
   assign in_tol    = abs_error <= ERR_W'(i_config.threshold > THRESHOLD_MAX ?
                                          THRESHOLD_MAX : i_config.threshold);
   // Pulse-train motion is not an internal operation and never sets busy
   assign op_any    = |i_ops;
   assign start_any = i_start | i_train_pulse;

   // Timers
   logic              op_prev;
   logic              hold_load;
   logic              hold_running;
   logic              stab_load;
   logic              stab_running;
   logic              width_load;
   logic [TIME_W-1:0] width_value;
   logic              width_running;

   assign hold_load = op_any & ~op_prev;

   mst_timer u_hold_timer (
      .i_clock   (i_clock),
      .i_arst_n  (i_arst_n),
      .i_tick    (tick),
      .i_load    (hold_load),
      .i_value   (min_ticks(i_config.busy_hold_time)),
      .o_running (hold_running)
   );

   mst_timer u_stab_timer (
      .i_clock   (i_clock),
      .i_arst_n  (i_arst_n),
      .i_tick    (tick),
      .i_load    (stab_load),
      .i_value   (min_ticks(i_config.settle_stability_time)),
      .o_running (stab_running)
   );

   mst_timer u_width_timer (
      .i_clock   (i_clock),
      .i_arst_n  (i_arst_n),
      .i_tick    (tick),
      .i_load    (width_load),
      .i_value   (width_value),
      .o_running (width_running)
   );

   // Settled reporting
   mst_state_type state;
   mst_state_type next_state;
   logic          next_settled;

   always_comb begin
      abort = ~i_servo_active | i_alarm_stop | i_warning_stop | i_limit_stop |
              (i_halt_request & (state == ST_MOVING));
   end

   always_comb begin
      next_state  = state;
      stab_load   = 1'b0;
      width_load  = 1'b0;
      width_value = TIME_ZERO;
      case (state)
         ST_MOVING: begin
            if (i_target_reached | i_train_pause) begin
               next_state = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (!in_tol && mode != MODE_TRACKING) begin
               stab_load = 1'b1;
            end else if (!stab_running && !width_running) begin
               if (mode == MODE_PULSED) begin
                  next_state  = ST_PULSE;
                  width_load  = 1'b1;
                  width_value = width_mag(i_config.settle_report_mode_width);
               end else begin
                  next_state = ST_HELD;
               end
            end
         end
         ST_PULSE: begin
            if (!width_running) begin
               next_state = ST_DONE;
            end
         end
         ST_LOST, ST_HELD, ST_DONE: begin
            next_state = state;
         end
         default: begin
            next_state = ST_LOST;
         end
      endcase
      if (start_any) begin
         next_state = ST_MOVING;
         stab_load  = 1'b1;
         if (mode == MODE_LATCHED) begin
            width_load  = 1'b1;
            width_value = min_ticks(width_mag(i_config.settle_report_mode_width));
         end
      end
      if (abort) begin
         next_state = ST_LOST;
      end
   end

   always_comb begin
      case (next_state)
         ST_HELD: begin
            next_settled = (mode == MODE_TRACKING) ? in_tol : 1'b1;
         end
         ST_PULSE: begin
            next_settled = 1'b1;
         end
         default: begin
            next_settled = 1'b0;
         end
      endcase
   end

   // Output registers
   logic next_busy;
   logic next_accept;
   logic next_alert;

   always_comb begin
      next_busy   = op_any | hold_running;
      next_accept = i_servo_active & ~op_any;
      next_alert  = i_init_done & ~i_warning;
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state             <= ST_LOST;
         op_prev           <= 1'b0;
         o_servo_state_out <= 1'b0;
         o_busy_out        <= 1'b0;
         o_settled_out     <= 1'b0;
         o_alert_flag      <= 1'b0;
         o_cmd_accept      <= 1'b0;
      end else begin
         state             <= next_state;
         op_prev           <= op_any;
         o_servo_state_out <= i_servo_active;
         o_busy_out        <= next_busy;
         o_settled_out     <= next_settled;
         o_alert_flag      <= next_alert;
         o_cmd_accept      <= next_accept;
      end
   end

   // Checks
   a_servo_follow: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      ##1 o_servo_state_out == $past(i_servo_active))
      else $error("servo state output does not follow servo");

   a_busy_during_op: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      op_any |=> o_busy_out)
      else $error("busy open during operation");

   a_busy_idle: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (!op_any && !hold_running) |=> !o_busy_out)
      else $error("busy closed with no operation");

   a_busy_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      ($rose(op_any) && i_config.busy_hold_time != TIME_ZERO) |=> hold_running [*8])
      else $error("busy hold timer not started");

   a_accept_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (hold_running && !op_any && i_servo_active) |=> (o_busy_out && o_cmd_accept))
      else $error("command refused during hold window");

   a_reset_open: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (state == ST_LOST || state == ST_MOVING) |-> !o_settled_out)
      else $error("settled closed without completed positioning");

   a_loss_open: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (!i_servo_active || i_alarm_stop || i_limit_stop) |=> (!o_settled_out && state == ST_LOST))
      else $error("settled closed after target loss");

   a_start_opens: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (start_any && !abort) |=> (!o_settled_out && state == ST_MOVING))
      else $error("settled not opened by start");

   a_stab_blocks: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (stab_running && state != ST_HELD) |-> !o_settled_out)
      else $error("settled closed inside stability time");

   a_close_in_tol: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      ($rose(o_settled_out) && $past(mode) != MODE_TRACKING) |-> $past(in_tol))
      else $error("settled closed out of tolerance");

   a_track_follow: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (next_state == ST_HELD && mode == MODE_TRACKING) |=> o_settled_out == $past(in_tol))
      else $error("tracking output does not follow tolerance");

   a_pulse_ends: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (state == ST_PULSE && !width_running) |=> !o_settled_out)
      else $error("settled pulse not ended");

   a_alert_flag: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      ##1 o_alert_flag == $past(i_init_done && !i_warning))
      else $error("alert flag wrong");

endmodule
`default_nettype wire

/* mst_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mst_ctrl_model (
   // Clock
   input  wire logic i_clock,
   // Request from the bench and status seen by the controller
   input  wire logic i_go,
   input  wire logic i_servo_closed,
   input  wire logic i_alert_closed,
   input  wire logic i_halt,
   // Start pulse toward the drive
   output var logic  o_start
);
   logic armed = 1'b0;
   initial o_start = 1'b0;
   // Only ask for a move once the drive says it can take one
   always @(posedge i_clock) armed <= i_go & i_servo_closed & i_alert_closed & ~i_halt;
   // Launched off the falling edge so the drive samples a settled pulse
   always @(negedge i_clock) o_start <= armed;
endmodule
`default_nettype wire

/* mst_motion_status_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module mst_motion_status_bench
   import mst_pkg::*;
;
   localparam int TK = 10;
   logic i_clock = 1'b0;
   logic i_arst_n = 1'b0;
   mst_config_type cfg = '{DEF_BUSY_HOLD, DEF_MODE_WIDTH, DEF_THRESHOLD, DEF_STABILITY};
   mst_ops_type ops = 5'h00;
   logic init_done = 1'b0, servo = 1'b0, warn = 1'b0, halt = 1'b0, go = 1'b0;
   logic start, t_pulse = 1'b0, t_pause = 1'b0, reached = 1'b0;
   logic [2:0] stops = 3'h0;
   logic signed [ERR_W-1:0] err = 32'h00000000;
   logic servo_out, busy, settled, alert, accept;
   logic [THR_W-1:0] thr;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int t, hl;
   logic signed [WIDTH_W-1:0] fws [5] = '{18'h3FFFD, 18'h3FFFF, 18'h00000, 18'h00004,
                                          DEF_MODE_WIDTH};
   logic [TIME_W-1:0] iss [5] = '{17'h00002, 17'h00004, 17'h00003, 17'h00001, DEF_STABILITY};

   mst_motion_status #(.P_TICK_CYCLES(TK)) i_mst_motion_status (
      .i_clock(i_clock), .i_arst_n(i_arst_n), .i_config(cfg), .i_init_done(init_done),
      .i_servo_active(servo), .i_warning(warn), .i_halt_request(halt), .i_ops(ops),
      .i_start(start), .i_target_reached(reached), .i_train_pulse(t_pulse),
      .i_train_pause(t_pause), .i_alarm_stop(stops[0]), .i_warning_stop(stops[1]),
      .i_limit_stop(stops[2]), .i_residual_error(err), .o_servo_state_out(servo_out),
      .o_busy_out(busy), .o_settled_out(settled), .o_alert_flag(alert),
      .o_cmd_accept(accept));

   mst_ctrl_model i_mst_ctrl_model (
      .i_clock(i_clock), .i_go(go), .i_servo_closed(servo_out), .i_alert_closed(alert),
      .i_halt(halt), .o_start(start));

   always #5 i_clock = ~i_clock;

   // The whole sequence needs well under 10000 cycles
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (num_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic in_range(string what, int lo, int hi, int got);
      comparisons++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   task automatic cyc(int n);
      repeat (n) @(negedge i_clock);
   endtask

   task automatic issue();
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      cyc(1);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(1);
   endtask

   task automatic wait_out(logic lvl, int lim, output int n);
      n = 0;
      while (settled !== lvl && n < lim) begin
         cyc(1);
         n++;
      end
   endtask

   // Ticks the output must stay open after a start
   function automatic int open_ticks(logic signed [WIDTH_W-1:0] fw, logic [TIME_W-1:0] is);
      int w;
      w = (fw < 0) ? -int'(fw) : 0;
      return (w > int'(is)) ? w : int'(is);
   endfunction

   task automatic settle(logic signed [WIDTH_W-1:0] fw, logic [TIME_W-1:0] is);
      int o;
      o = open_ticks(fw, is);
      cfg.settle_report_mode_width = fw;
      cfg.settle_stability_time = is;
      err = thr;
      issue();
      cmp("open after start", 1'b0, settled);
      pulse(reached);
      wait_out(1'b1, 2000, t);
      in_range("settle delay", o * TK - 4, (o + 1) * TK + 2, t);
   endtask

   initial begin
      void'($urandom(24065));
      cyc(20);
      i_arst_n = 1'b1;
      cyc(2);
      cmp("settled", 1'b0, settled);
      repeat (30) begin
         servo = 1'($urandom);
         warn = 1'($urandom);
         init_done = 1'($urandom);
         cyc(2);
         cmp("servo state", servo, servo_out);
         cmp("alert", init_done & ~warn, alert);
         cmp("accept", servo, accept);
      end
      servo = 1'b1;
      warn = 1'b0;
      init_done = 1'b1;
      cyc(40);
      cmp("settled", 1'b0, settled);
      for (int i = 0; i < 5; i++) begin
         cfg.busy_hold_time = (i % 2) ? 17'h00003 : 17'h00000;
         hl = int'(cfg.busy_hold_time);
         ops[i] = 1'b1;
         cyc(1);
         ops = 5'h00;
         t = 0;
         while (busy === 1'b1 && t < 500) begin
            if (t == 5) cmp("accept in hold", 1'b1, accept);
            cyc(1);
            t++;
         end
         in_range("busy width", (hl > 0) ? hl * TK : 1, (hl + 1) * TK + 1, t);
      end
      // Small random threshold keeps the in-band values exactly on its edge
      thr = 22'($urandom_range(4000, 1));
      cfg.threshold = thr;
      cfg.settle_report_mode_width = 18'h3FFFF;
      cfg.settle_stability_time = 17'h00002;
      err = 32'sh0 - thr;
      repeat (3) begin
         pulse(t_pulse);
         cyc(3);
      end
      pulse(t_pause);
      cmp("busy on train", 1'b0, busy);
      wait_out(1'b1, 200, t);
      in_range("train settle", 0, 3 * TK + 2, t);
      foreach (fws[k]) begin
         settle(fws[k], iss[k]);
         if (fws[k] < 0) begin
            cyc(60);
            cmp("latched hold", 1'b1, settled);
         end else if (fws[k] == 0) begin
            err = thr + 1;
            cyc(3);
            cmp("tracking out", 1'b0, settled);
            err = 32'sh0 - thr;
            cyc(3);
            cmp("tracking in", 1'b1, settled);
         end else begin
            wait_out(1'b0, 2000, t);
            in_range("pulse width", (int'(fws[k]) - 1) * TK - 1, int'(fws[k]) * TK + 1, t);
         end
      end
      settle(18'h00014, 17'h00000);
      issue();
      cmp("pulse cut", 1'b0, settled);
      cfg.settle_report_mode_width = 18'h3FFFF;
      cfg.settle_stability_time = 17'h00003;
      err = thr + 1;
      issue();
      pulse(reached);
      cyc(60);
      cmp("settled out of band", 1'b0, settled);
      err = thr;
      wait_out(1'b1, 500, t);
      in_range("stability", 3 * TK - 2, 4 * TK + 3, t);
      for (int k = 0; k < 5; k++) begin
         err = thr;
         issue();
         if (k < 3) stops[k] = 1'b1;
         else if (k == 3) halt = 1'b1;
         else servo = 1'b0;
         cyc(1);
         stops = 3'h0;
         halt = 1'b0;
         servo = 1'b1;
         cyc(1);
         pulse(reached);
         cyc(60);
         cmp("settled after loss", 1'b0, settled);
      end
      settle(18'h3FFFF, 17'h00000);
      servo = 1'b0;
      cyc(3);
      cmp("settled servo off", 1'b0, settled);
      servo = 1'b1;
      cyc(2);
      print_verdict();
   end
endmodule
`default_nettype wire
